/* File: core/dncs_cfg.svh */
`ifndef DNCS_CFG_SVH
`define DNCS_CFG_SVH

// Clock and timing
`define DNCS_CLK_NS 20
`define DNCS_TICK_NS 100000000
`define DNCS_TENTHS_MAX 32'd9990

// Device register word addresses
`define DNCS_A_CTRL 10'h000
`define DNCS_A_HOLD 10'h001
`define DNCS_A_SER 10'h002
`define DNCS_A_STN 10'h003
`define DNCS_A_TMO 10'h004
`define DNCS_A_STAT 10'h005
`define DNCS_A_MASK 10'h006
`define DNCS_A_STATE 10'h007
`define DNCS_A_RMAP_HI 3'h2
`define DNCS_A_WMAP_HI 3'h3

// Field positions
`define DNCS_F_TRIP 1:0
`define DNCS_F_ACT 4:2
`define DNCS_F_IPSRC 5
`define DNCS_F_PROTO 1:0
`define DNCS_F_BAUD 3:2
`define DNCS_F_FMT 6:4

// Status bits
`define DNCS_S_ALARM 0
`define DNCS_S_FAULT 1
`define DNCS_S_LOST 2
`define DNCS_S_REJ 3

// Reset values and limits
`define DNCS_RST_TRIP 2'h2
`define DNCS_RST_ACT 3'h2
`define DNCS_RST_IPSRC 1'h1
`define DNCS_RST_PROTO 2'h2
`define DNCS_RST_BAUD 2'h1
`define DNCS_RST_FMT 3'h1
`define DNCS_RST_STN 8'h01
`define DNCS_STN_MAX 32'd247
`define DNCS_PAR_MAX 32'd9999
`define DNCS_SLOTS 7'd100
`define DNCS_ALARM_CODE 8'h88

// Controller register word addresses
`define DNCS_H_CTL 4'h0
`define DNCS_H_WR 4'h1
`define DNCS_H_RD 4'h2
`define DNCS_H_RDAT 4'h3
`define DNCS_H_RX 4'h4
`define DNCS_H_SER 4'h5
`define DNCS_H_STAT 4'h6
`define DNCS_H_MASK 4'h7

`endif

/* File: core/dncs_dev.sv */
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dncs_cfg.svh"
module dncs_dev #(
  parameter int TICK_CYC = `DNCS_TICK_NS / `DNCS_CLK_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Link
  dncs_link_if.dev lnk,
  // Register port
  input wire logic [9:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq,
  // Drive parameter access
  output logic [13:0] par_raddr,
  output logic par_rd,
  input wire logic [15:0] par_rdata,
  output logic [13:0] par_waddr,
  output logic [15:0] par_wdata,
  output logic par_wr,
  // Drive control
  input wire logic motor_running,
  input wire logic cmd_from_net,
  output logic fault,
  output logic alarm,
  output logic [7:0] alarm_code,
  output logic [3:0] net_act,
  output logic link_lost,
  output logic ip_from_dhcp
);
  function automatic logic le(input logic [31:0] v, input logic [31:0] hi);
    le = v <= hi;
  endfunction

  logic [1:0] trip_r, proto_r, baud_r;
  logic [2:0] act_r, fmt_r;
  logic ipsrc_r;
  logic [9:0] hold_r, tmo_r, hcnt_r, tcnt_r;
  logic [7:0] stn_r;
  logic [3:0] st_r, mask_r, st_nxt;
  logic [13:0] rmap_r [0:99];
  logic [13:0] wmap_r [0:99];
  logic [31:0] rdata_r, hpre_r, tpre_r;
  logic armed_r, prun_r, alarm_r, fault_r, irq_r, online_r, lost_r, seen_r;
  logic [3:0] nact_r;
  logic [7:0] code_r;
  logic prd_r, rdp_r, bad1_r, bad2_r, rdv_r, pwr_r;
  logic [13:0] praddr_r, pwaddr_r;
  logic [15:0] pwdata_r, rddat_r;

  // Register decode
  wire [6:0] slot = sw_addr[6:0];
  wire slot_ok = slot < `DNCS_SLOTS;
  wire a_rmap = sw_addr[9:7] == `DNCS_A_RMAP_HI && slot_ok;
  wire a_wmap = sw_addr[9:7] == `DNCS_A_WMAP_HI && slot_ok;
  wire a_ctrl = sw_addr == `DNCS_A_CTRL;
  wire a_hold = sw_addr == `DNCS_A_HOLD;
  wire a_ser = sw_addr == `DNCS_A_SER;
  wire a_stn = sw_addr == `DNCS_A_STN;
  wire a_tmo = sw_addr == `DNCS_A_TMO;
  wire stop_only = a_ser | a_stn | a_tmo | a_rmap | a_wmap;
  wire bad_val =
    (a_ctrl && !(le({30'h0, sw_wdata[`DNCS_F_TRIP]}, 32'd2) &&
                 le({29'h0, sw_wdata[`DNCS_F_ACT]}, 32'd4))) ||
    (a_hold && !le(sw_wdata, `DNCS_TENTHS_MAX)) ||
    (a_tmo && !le(sw_wdata, `DNCS_TENTHS_MAX)) ||
    (a_ser && !le({30'h0, sw_wdata[`DNCS_F_PROTO]}, 32'd2)) ||
    (a_ser && !le({29'h0, sw_wdata[`DNCS_F_FMT]}, 32'd5)) ||
    (a_stn && (sw_wdata[7:0] == 8'h00 || !le(sw_wdata, `DNCS_STN_MAX))) ||
    ((a_rmap | a_wmap) && !le(sw_wdata, `DNCS_PAR_MAX));
  wire rej = sw_wr && ((stop_only && motor_running) || bad_val);
  wire wr_ok = sw_wr && !rej;

  // Master state supervision
  wire is_run = lnk.mst_state == dncs_pkg::MST_RUN;
  wire is_cfg = lnk.mst_state == dncs_pkg::MST_CFG;
  wire ev_cfg = armed_r && prun_r && is_cfg;
  wire trip_alarm = trip_r == dncs_pkg::TRIP_ALARM;
  wire trip_fault = trip_r == dncs_pkg::TRIP_FAULT;
  wire [3:0] act_vec =
    (act_r == dncs_pkg::ACT_RAMP) ? 4'h1 :
    (act_r == dncs_pkg::ACT_DISABLE) ? 4'h2 :
    (act_r == dncs_pkg::ACT_REM1) ? 4'h4 :
    (act_r == dncs_pkg::ACT_REM2) ? 4'h8 : 4'h0;

  // Cyclic write hold-off
  wire on_rise = lnk.online && !online_r;
  wire htick = hpre_r == TICK_CYC - 1;
  wire hold_act = on_rise ? (hold_r != 10'h000) : (hcnt_r != 10'h000);
  wire wslot_ok = lnk.wr_slot < `DNCS_SLOTS;

  // Serial silence supervision
  // only code 2 runs the slave
  wire ser_en = proto_r == 2'h2;
  wire rx_ok = lnk.ser_rx && ser_en && lnk.ser_station == stn_r;
  wire ttick = tpre_r == TICK_CYC - 1;
  wire lost_nxt = ser_en && seen_r && tmo_r != 10'h000 && !rx_ok &&
                  (lost_r || (ttick && tcnt_r >= tmo_r - 10'h001));

  wire [3:0] ev = {rej, lost_nxt && !lost_r, ev_cfg && trip_fault, ev_cfg && trip_alarm};
  wire [3:0] clr = (sw_wr && sw_addr == `DNCS_A_STAT) ? sw_wdata[3:0] : 4'h0;
  wire [31:0] rd_mux =
    a_ctrl ? {26'h0, ipsrc_r, act_r, trip_r} :
    a_hold ? {22'h0, hold_r} :
    a_ser ? {25'h0, fmt_r, baud_r, proto_r} :
    a_stn ? {24'h0, stn_r} :
    a_tmo ? {22'h0, tmo_r} :
    (sw_addr == `DNCS_A_STAT) ? {28'h0, st_r} :
    (sw_addr == `DNCS_A_MASK) ? {28'h0, mask_r} :
    (sw_addr == `DNCS_A_STATE) ? {24'h0, lnk.mst_state, lost_r, hold_act, online_r,
                                  fault_r, alarm_r, armed_r} :
    a_rmap ? {18'h0, rmap_r[slot]} :
    a_wmap ? {18'h0, wmap_r[slot]} : 32'h0;
  // Set wins over a clear in the same cycle
  assign st_nxt = (st_r & ~clr) | ev;

  // Settings
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trip_r <= `DNCS_RST_TRIP;
      act_r <= `DNCS_RST_ACT;
      ipsrc_r <= `DNCS_RST_IPSRC;
      hold_r <= 10'h000;
      proto_r <= `DNCS_RST_PROTO;
      baud_r <= `DNCS_RST_BAUD;
      fmt_r <= `DNCS_RST_FMT;
      stn_r <= `DNCS_RST_STN;
      tmo_r <= 10'h000;
      mask_r <= 4'h0;
    end else if (ce && wr_ok) begin
      if (a_ctrl) begin
        trip_r <= sw_wdata[`DNCS_F_TRIP];
        act_r <= sw_wdata[`DNCS_F_ACT];
        ipsrc_r <= sw_wdata[`DNCS_F_IPSRC];
      end
      if (a_hold) hold_r <= sw_wdata[9:0];
      if (a_ser) begin
        proto_r <= sw_wdata[`DNCS_F_PROTO];
        baud_r <= sw_wdata[`DNCS_F_BAUD];
        fmt_r <= sw_wdata[`DNCS_F_FMT];
      end
      if (a_stn) stn_r <= sw_wdata[7:0];
      if (a_tmo) tmo_r <= sw_wdata[9:0];
      if (sw_addr == `DNCS_A_MASK) mask_r <= sw_wdata[3:0];
    end
  end

  // Word maps
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 100; i++) begin
        rmap_r[i] <= 14'h0000;
        wmap_r[i] <= 14'h0000;
      end
    end else if (ce && wr_ok) begin
      if (a_rmap) rmap_r[slot] <= sw_wdata[13:0];
      if (a_wmap) wmap_r[slot] <= sw_wdata[13:0];
    end
  end

  // Supervision, alarm and fault
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
      prun_r <= 1'b0;
      alarm_r <= 1'b0;
      fault_r <= 1'b0;
      nact_r <= 4'h0;
      code_r <= 8'h00;
      st_r <= 4'h0;
      irq_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (ce) begin
      if (is_run) armed_r <= 1'b1;
      prun_r <= is_run;
      // alarm held while master stays out of run and trip stays on alarm
      if (ev_cfg && trip_alarm) alarm_r <= 1'b1;
      else if (is_run || !trip_alarm) alarm_r <= 1'b0;
      code_r <= ((ev_cfg || (alarm_r && !is_run)) && trip_alarm) ? `DNCS_ALARM_CODE : 8'h00;
      if (ev_cfg && trip_fault) fault_r <= 1'b1;
      else if (clr[`DNCS_S_FAULT]) fault_r <= 1'b0;
      nact_r <= (alarm_r && trip_alarm && cmd_from_net) ? act_vec : 4'h0;
      st_r <= st_nxt;
      irq_r <= |(st_nxt & mask_r);
      rdata_r <= sw_rd ? rd_mux : 32'h0;
    end
  end

  // Cyclic data and timers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      online_r <= 1'b0;
      hcnt_r <= 10'h000;
      hpre_r <= 32'h0;
      tcnt_r <= 10'h000;
      tpre_r <= 32'h0;
      seen_r <= 1'b0;
      lost_r <= 1'b0;
      pwr_r <= 1'b0;
      pwaddr_r <= 14'h0000;
      pwdata_r <= 16'h0000;
      prd_r <= 1'b0;
      praddr_r <= 14'h0000;
      rdp_r <= 1'b0;
      bad1_r <= 1'b0;
      bad2_r <= 1'b0;
      rdv_r <= 1'b0;
      rddat_r <= 16'h0000;
    end else if (ce) begin
      online_r <= lnk.online;
      if (on_rise) begin
        hcnt_r <= hold_r;
        hpre_r <= 32'h0;
      end else if (hcnt_r != 10'h000) begin
        hpre_r <= htick ? 32'h0 : hpre_r + 32'h1;
        if (htick) hcnt_r <= hcnt_r - 10'h001;
      end
      pwr_r <= lnk.wr_valid && lnk.online && !hold_act && wslot_ok;
      if (lnk.wr_valid && wslot_ok) begin
        pwaddr_r <= wmap_r[lnk.wr_slot];
        pwdata_r <= lnk.wr_data;
      end
      if (rx_ok) begin
        seen_r <= 1'b1;
        tcnt_r <= 10'h000;
        tpre_r <= 32'h0;
      end else if (!lost_r) begin
        tpre_r <= ttick ? 32'h0 : tpre_r + 32'h1;
        if (ttick) tcnt_r <= tcnt_r + 10'h001;
      end
      lost_r <= lost_nxt;
      prd_r <= lnk.rd_req && lnk.rd_slot < `DNCS_SLOTS;
      bad1_r <= lnk.rd_req && !(lnk.rd_slot < `DNCS_SLOTS);
      if (lnk.rd_req && lnk.rd_slot < `DNCS_SLOTS) praddr_r <= rmap_r[lnk.rd_slot];
      rdp_r <= prd_r;
      bad2_r <= bad1_r;
      rdv_r <= rdp_r || bad2_r;
      rddat_r <= rdp_r ? par_rdata : 16'h0000;
    end
  end

  assign lnk.rd_valid = rdv_r;
  assign lnk.rd_data = rddat_r;
  assign lnk.dev_baud = baud_r;
  assign lnk.dev_fmt = fmt_r;
  assign lnk.dev_ser_en = ser_en;
  assign sw_rdata = rdata_r;
  assign irq = irq_r;
  assign par_raddr = praddr_r;
  assign par_rd = prd_r;
  assign par_waddr = pwaddr_r;
  assign par_wdata = pwdata_r;
  assign par_wr = pwr_r;
  assign fault = fault_r;
  assign alarm = alarm_r;
  assign alarm_code = code_r;
  assign net_act = nact_r;
  assign link_lost = lost_r;
  assign ip_from_dhcp = ipsrc_r;
endmodule
`default_nettype wire

/* File: core/dncs_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dncs_link_if;
  logic [1:0] mst_state;
  logic online;
  logic wr_valid;
  dncs_pkg::dncs_slot_t wr_slot;
  logic [15:0] wr_data;
  logic rd_req;
  dncs_pkg::dncs_slot_t rd_slot;
  logic rd_valid;
  logic [15:0] rd_data;
  logic ser_rx;
  logic [7:0] ser_station;
  logic [1:0] dev_baud;
  logic [2:0] dev_fmt;
  logic dev_ser_en;
  modport dev (
    input mst_state, online, wr_valid, wr_slot, wr_data, rd_req, rd_slot, ser_rx, ser_station,
    output rd_valid, rd_data, dev_baud, dev_fmt, dev_ser_en
  );
  modport mst (
    output mst_state, online, wr_valid, wr_slot, wr_data, rd_req, rd_slot, ser_rx, ser_station,
    input rd_valid, rd_data, dev_baud, dev_fmt, dev_ser_en
  );
endinterface
`default_nettype wire

/* File: core/dncs_mst.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dncs_cfg.svh"
module dncs_mst (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Link
  dncs_link_if.mst lnk,
  // Register port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq
);
  logic [2:0] ctl_r;
  logic wr_r, rd_r, rx_r, irq_r;
  dncs_pkg::dncs_slot_t wslot_r, rslot_r;
  logic [15:0] wdat_r, rdat_r;
  logic [7:0] stn_r;
  logic [4:0] ser_r;
  logic [1:0] st_r, mask_r, st_nxt;
  logic [31:0] rdata_r;

  wire hit = sw_wr;
  wire w_ctl = hit && sw_addr == `DNCS_H_CTL;
  wire w_wr = hit && sw_addr == `DNCS_H_WR;
  wire w_rd = hit && sw_addr == `DNCS_H_RD;
  wire w_rx = hit && sw_addr == `DNCS_H_RX;
  wire w_ser = hit && sw_addr == `DNCS_H_SER;
  wire w_stat = hit && sw_addr == `DNCS_H_STAT;
  wire w_mask = hit && sw_addr == `DNCS_H_MASK;
  wire baud_bad = lnk.dev_baud != ser_r[1:0];
  wire fmt_bad = lnk.dev_fmt != ser_r[4:2];
  wire [1:0] ev = {baud_bad | fmt_bad, lnk.rd_valid};
  wire [1:0] clr = w_stat ? sw_wdata[1:0] : 2'h0;
  wire [31:0] rd_mux =
    (sw_addr == `DNCS_H_CTL) ? {29'h0, ctl_r} :
    (sw_addr == `DNCS_H_RDAT) ? {16'h0, rdat_r} :
    (sw_addr == `DNCS_H_SER) ? {27'h0, ser_r} :
    (sw_addr == `DNCS_H_STAT) ? {30'h0, st_r} :
    (sw_addr == `DNCS_H_MASK) ? {30'h0, mask_r} : 32'h0;
  assign st_nxt = (st_r & ~clr) | ev;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= 3'h0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rx_r <= 1'b0;
      wslot_r <= 7'h00;
      rslot_r <= 7'h00;
      wdat_r <= 16'h0000;
      rdat_r <= 16'h0000;
      stn_r <= `DNCS_RST_STN;
      ser_r <= {`DNCS_RST_FMT, `DNCS_RST_BAUD};
      st_r <= 2'h0;
      mask_r <= 2'h0;
      irq_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (ce) begin
      if (w_ctl) begin
        ctl_r <= sw_wdata[2:0];
      end
      wr_r <= w_wr;
      if (w_wr) begin
        wslot_r <= sw_wdata[22:16];
        wdat_r <= sw_wdata[15:0];
      end
      rd_r <= w_rd;
      if (w_rd) begin
        rslot_r <= sw_wdata[6:0];
      end
      rx_r <= w_rx;
      if (w_rx) begin
        stn_r <= sw_wdata[7:0];
      end
      if (w_ser) begin
        ser_r <= sw_wdata[4:0];
      end
      if (lnk.rd_valid) begin
        rdat_r <= lnk.rd_data;
      end
      st_r <= st_nxt;
      if (w_mask) begin
        mask_r <= sw_wdata[1:0];
      end
      irq_r <= |(st_nxt & mask_r);
      rdata_r <= sw_rd ? rd_mux : 32'h0;
    end
  end

  assign lnk.mst_state = ctl_r[1:0];
  assign lnk.online = ctl_r[2];
  assign lnk.wr_valid = wr_r;
  assign lnk.wr_slot = wslot_r;
  assign lnk.wr_data = wdat_r;
  assign lnk.rd_req = rd_r;
  assign lnk.rd_slot = rslot_r;
  assign lnk.ser_rx = rx_r;
  assign lnk.ser_station = stn_r;
  assign sw_rdata = rdata_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

/* File: core/dncs_pkg.sv */
package dncs_pkg;
  typedef enum logic [1:0] {
    MST_OFF = 2'b00,
    MST_RUN = 2'b01,
    MST_CFG = 2'b10
  } dncs_mst_e;
  typedef enum logic [1:0] {
    TRIP_OFF = 2'b00,
    TRIP_FAULT = 2'b01,
    TRIP_ALARM = 2'b10
  } dncs_trip_e;
  typedef enum logic [2:0] {
    ACT_NONE = 3'b000,
    ACT_RAMP = 3'b001,
    ACT_DISABLE = 3'b010,
    ACT_REM1 = 3'b011,
    ACT_REM2 = 3'b100
  } dncs_act_e;
  typedef logic [6:0] dncs_slot_t;
  typedef logic [13:0] dncs_par_t;
endpackage

/* File: verif/dncs_link_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dncs_link_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link
  input wire logic [1:0] mst_state,
  input wire logic online,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire dncs_pkg::dncs_slot_t rd_slot,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic [1:0] dev_baud,
  input wire logic [2:0] dev_fmt,
  input wire logic dev_ser_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_rd_latency: assert property (rd_req |-> ##3 rd_valid)
    else $error("Read answer late");
  a_rd_no_spur: assert property (rd_valid |-> $past(rd_req, 3))
    else $error("Read answer without request");
  a_rd_oob_zero: assert property (rd_req && rd_slot >= 7'd100 |-> ##3 rd_data == 16'h0000)
    else $error("Slot beyond range not zero");
  a_rd_isolated: assert property (rd_req ##1 !rd_req |-> ##2 rd_valid ##1 !rd_valid)
    else $error("Read answer not one cycle");
  a_fmt_legal: assert property (dev_fmt <= 3'h5)
    else $error("Frame format out of range");
  a_mst_legal: assert property (mst_state != 2'b11)
    else $error("Master state code illegal");
  a_reset_rate: assert property ($rose(resetn) |-> dev_baud == 2'h1 && dev_fmt == 3'h1)
    else $error("Serial defaults wrong");
  a_reset_proto: assert property ($rose(resetn) |-> dev_ser_en)
    else $error("Serial slave not enabled");
  c_read: cover property (rd_req ##3 rd_valid);
  c_cfg: cover property (mst_state == 2'h1 ##1 mst_state == 2'h2);
  c_write: cover property (wr_valid && online);
endmodule
`default_nettype wire

/* File: verif/drive_network_comm_supervisor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dncs_cfg.svh"
module drive_network_comm_supervisor_tb;
  logic ref_clk, resetn, ce, d_wr, d_rd, m_wr, m_rd, motor_running, cmd_from_net;
  logic d_irq, m_irq, par_rd, par_wr, fault, alarm, link_lost, ip_from_dhcp, m, c;
  logic [9:0] addr;
  logic [31:0] wdata, d_rdata, m_rdata, lw, nw, n0, n_errors, n_checks;
  logic [13:0] par_raddr, par_waddr, p;
  logic [15:0] par_rdata, par_wdata, dv;
  logic [7:0] alarm_code;
  logic [3:0] net_act;
  logic [6:0] s;
  logic [9:0] ba [8] = '{10'h000, 10'h000, 10'h003, 10'h003, 10'h002, 10'h002, 10'h001, 10'h100};
  logic [31:0] bv [8] = '{32'h2B, 32'h36, 32'h0, 32'hF8, 32'h66, 32'h17, 32'h2707, 32'h2710};
  logic [31:0] be [4] = '{32'h2A, 32'h1, 32'h16, 32'h0};
  dncs_link_if lnk ();
  dncs_dev #(.TICK_CYC(10)) dncs_dev_i (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .lnk(lnk.dev), .sw_addr(addr), .sw_wdata(wdata), .sw_wr(d_wr), .sw_rd(d_rd),
    .sw_rdata(d_rdata), .irq(d_irq), .par_raddr(par_raddr), .par_rd(par_rd),
    .par_rdata(par_rdata), .par_waddr(par_waddr), .par_wdata(par_wdata), .par_wr(par_wr),
    .motor_running(motor_running), .cmd_from_net(cmd_from_net), .fault(fault),
    .alarm(alarm), .alarm_code(alarm_code), .net_act(net_act), .link_lost(link_lost),
    .ip_from_dhcp(ip_from_dhcp));
  dncs_mst dncs_mst_i (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .lnk(lnk.mst),
    .sw_addr(addr[3:0]), .sw_wdata(wdata), .sw_wr(m_wr), .sw_rd(m_rd), .sw_rdata(m_rdata),
    .irq(m_irq));
  dncs_link_props dncs_link_props_i (.ref_clk(ref_clk), .resetn(resetn),
    .mst_state(lnk.mst_state), .online(lnk.online), .wr_valid(lnk.wr_valid),
    .rd_req(lnk.rd_req), .rd_slot(lnk.rd_slot), .rd_valid(lnk.rd_valid),
    .rd_data(lnk.rd_data), .dev_baud(lnk.dev_baud), .dev_fmt(lnk.dev_fmt),
    .dev_ser_en(lnk.dev_ser_en));

  always #10 ref_clk = ~ref_clk;

  // Drive side: answers a read one cycle later, shows noise otherwise
  always @(posedge ref_clk) par_rdata <= par_rd ? pv(par_raddr) : ~par_rdata;
  always @(posedge ref_clk) begin
    if (par_wr) begin
      nw <= nw + 1;
      lw <= {2'h0, par_waddr, par_wdata};
    end
  end

  function automatic logic [15:0] pv(input logic [13:0] a);
    return {2'h2, a} ^ 16'h5A3C;
  endfunction

  function automatic logic [31:0] sup(input int t, input int a, input logic c, input logic m);
    logic [3:0] act;
    act = (t == 2 && c && a > 0) ? 4'(1 << (a - 1)) : 4'h0;
    return {17'h0, m && t == 2, t == 2, t == 1, (t == 2) ? `DNCS_ALARM_CODE : 8'h00, act};
  endfunction

  task automatic wr(input bit d, input logic [9:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    if (d) d_wr <= 1'b1;
    else m_wr <= 1'b1;
    @(posedge ref_clk);
    d_wr <= 1'b0;
    m_wr <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rchk(input bit d, input logic [9:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    if (d) d_rd <= 1'b1;
    else m_rd <= 1'b1;
    @(posedge ref_clk);
    d_rd <= 1'b0;
    m_rd <= 1'b0;
    @(negedge ref_clk);
    chk(d ? d_rdata : m_rdata, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    $display("[FAIL] %0t run did not finish", $time);
    give_verdict();
  end

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    {d_wr, d_rd, m_wr, m_rd, motor_running, cmd_from_net} = 6'h0;
    addr = '0;
    wdata = '0;
    par_rdata = '0;
    {nw, lw, n_errors, n_checks} = '0;
    void'($urandom(36));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk(1, `DNCS_A_CTRL, 32'h2A);
    rchk(1, `DNCS_A_SER, 32'h16);
    chk({31'h0, ip_from_dhcp}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(1, ba[k], bv[k]);
      rchk(1, `DNCS_A_STAT, 32'h8);
      rchk(1, ba[k], be[k / 2]);
      wr(1, `DNCS_A_STAT, 32'hF);
    end
    @(posedge ref_clk);
    motor_running <= 1'b1;
    wr(1, `DNCS_A_STN, 32'h5);
    rchk(1, `DNCS_A_STN, 32'h1);
    motor_running <= 1'b0;
    wr(0, `DNCS_H_CTL, 32'h2);
    settle(6);
    chk({30'h0, alarm, fault}, 32'h0);
    for (int t = 0; t < 3; t++) begin
      for (int a = 0; a < 5; a++) begin
        c = 1'($urandom);
        m = 1'($urandom);
        cmd_from_net <= c;
        wr(1, `DNCS_A_CTRL, {26'h1, 3'(a), 2'(t)});
        wr(1, `DNCS_A_MASK, {31'h0, m});
        wr(0, `DNCS_H_CTL, 32'h1);
        wr(0, `DNCS_H_CTL, 32'h2);
        settle(6);
        chk({17'h0, d_irq, alarm, fault, alarm_code, net_act}, sup(t, a, c, m));
        wr(0, `DNCS_H_CTL, 32'h1);
        wr(1, `DNCS_A_STAT, 32'hF);
        settle(4);
        chk({29'h0, d_irq, alarm, fault}, 32'h0);
      end
    end
    wr(0, `DNCS_H_CTL, 32'h5);
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 7'd99 : 7'($urandom_range(98));
      p = (i == 1) ? 14'd9999 : 14'($urandom_range(9999));
      dv = 16'($urandom);
      wr(1, 10'h100 + 10'(s), {18'h0, p});
      wr(1, 10'h180 + 10'(s), {18'h0, p});
      wr(0, `DNCS_H_RD, {25'h0, s});
      settle(6);
      rchk(0, `DNCS_H_RDAT, {16'h0, pv(p)});
      n0 = nw;
      wr(0, `DNCS_H_WR, {9'h0, s, dv});
      settle(4);
      chk(lw, {2'h0, p, dv});
      chk(nw, n0 + 1);
    end
    for (int k = 10; k < 12; k++) wr(1, 10'h100 + 10'(k), 32'd1234);
    wr(0, `DNCS_H_RD, 32'd11);
    settle(6);
    rchk(0, `DNCS_H_RDAT, {16'h0, pv(14'd1234)});
    wr(0, `DNCS_H_RD, 32'd100);
    settle(6);
    rchk(0, `DNCS_H_RDAT, 32'h0);
    wr(1, `DNCS_A_HOLD, 32'd2);
    wr(0, `DNCS_H_CTL, 32'h1);
    wr(0, `DNCS_H_CTL, 32'h5);
    n0 = nw;
    wr(0, `DNCS_H_WR, {9'h0, s, 16'h1234});
    settle(4);
    chk(nw, n0);
    settle(25);
    wr(0, `DNCS_H_WR, {9'h0, s, 16'h4321});
    settle(4);
    chk(nw, n0 + 1);
    for (int k = 0; k < 6; k++) begin
      wr(1, `DNCS_A_SER, {25'h0, 3'(k), 2'(k % 4), 2'(k % 3)});
      settle(2);
      chk({26'h0, lnk.dev_ser_en, lnk.dev_fmt, lnk.dev_baud},
          {26'h0, k % 3 == 2, 3'(k), 2'(k % 4)});
    end
    ce <= 1'b0;
    wr(1, `DNCS_A_STN, 32'h7);
    ce <= 1'b1;
    rchk(1, `DNCS_A_STN, 32'h1);
    wr(1, `DNCS_A_SER, 32'h16);
    wr(1, `DNCS_A_STN, 32'h5);
    wr(1, `DNCS_A_TMO, 32'h3);
    wr(0, `DNCS_H_RX, 32'h6);
    settle(40);
    chk({31'h0, link_lost}, 32'h0);
    wr(0, `DNCS_H_RX, 32'h5);
    settle(20);
    chk({31'h0, link_lost}, 32'h0);
    settle(20);
    chk({31'h0, link_lost}, 32'h1);
    wr(0, `DNCS_H_RX, 32'h5);
    settle(3);
    chk({31'h0, link_lost}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
